// ==== pkg/rwc_defines.svh ====
`ifndef RWC_DEFINES_SVH
`define RWC_DEFINES_SVH

// Target codes carried in the low three bits of every serial word.
`define RWC_ADDR_CLOCK      3'h4
`define RWC_ADDR_DEVIATION  3'h5
`define RWC_ADDR_STEP       3'h6
`define RWC_ADDR_DELAY      3'h7
`define RWC_F_ADDR          2:0

// Clock register fields.
`define RWC_B_LOAD_SYNC     31
`define RWC_F_MOD_MODE      30:26
`define RWC_F_STATUS        25:21
`define RWC_F_DIV_MODE      20:19
`define RWC_F_SECOND_DIV    18:7
`define RWC_B_DIV_SELECT    6

// Deviation register fields.
`define RWC_B_TRIG_FALLING  30
`define RWC_B_TRIG_RAMP_CLK 29
`define RWC_B_PARABOLIC     28
`define RWC_F_INT_MODE      27:26
`define RWC_B_KEYED_RAMP    25
`define RWC_B_DUAL_RAMP     24
`define RWC_B_WORD_SELECT   23
`define RWC_F_DEV_SHIFT     22:19
`define RWC_F_DEV_STEP      18:3

// Step register fields.
`define RWC_F_STEP_COUNT    22:3

// Delay register fields.
`define RWC_B_TRIG_DELAY    23
`define RWC_B_TRI_DELAY     22
`define RWC_B_SINGLE_TRI    21
`define RWC_B_TRIG_START    20
`define RWC_B_FAST_RAMP     19
`define RWC_B_DLY_FASTLOCK  18
`define RWC_B_RAMP_DELAY    17
`define RWC_B_DLY_CLK_SEL   16
`define RWC_B_DLY_START     15
`define RWC_F_DLY_WORD      14:3

// Field values.
`define RWC_MOD_INT_ONLY    5'h0E
`define RWC_MOD_NORMAL      5'h00
`define RWC_DIV_RAMP        2'h3
`define RWC_DIV_FASTLOCK    2'h1
`define RWC_STAT_READBACK   5'h02
`define RWC_STAT_RAMP_DONE  5'h03
`define RWC_STAT_CP_UP      5'h10
`define RWC_STAT_CP_DOWN    5'h11
`define RWC_INT_OFF         2'h0
`define RWC_INT_STOP        2'h3

// Reset values.
`define RWC_RST_WORD        32'h0000_0000
`define RWC_RST_PINS        4'h0

`endif

// ==== pkg/rwc_pkg.sv ====
package rwc_pkg;

  // Serial port pins as seen at the block boundary.
  typedef struct packed {
    logic sclk;
    logic sdata;
    logic load_latch_pin;
  } rwc_ser_t;

  // Pin order: [3] trigger, [2] serial clock, [1] serial data, [0] load latch.
  typedef logic [3:0] rwc_pins_t;

  // Synchroniser state: three stages and the agreed level.
  typedef struct packed {
    rwc_pins_t s1;
    rwc_pins_t s2;
    rwc_pins_t s3;
    rwc_pins_t filt;
  } rwc_sync_st_t;

  // Shift register state.
  typedef struct packed {
    logic [31:0] sh;
    logic        sclk_q;
    logic        latch_q;
    logic        pend;
    logic [31:0] word;
    logic        vld;
  } rwc_shift_st_t;

  // Decoded configuration driven to the ramp engine and loop.
  typedef struct packed {
    logic        load_sync_select;
    logic        int_only;
    logic        modulator_on;
    logic [4:0]  status_sel;
    logic        ramp_div_en;
    logic        fast_lock_en;
    logic [11:0] second_ramp_divider_a;
    logic [11:0] second_ramp_divider_b;
    logic        trig_falling;
    logic        trig_ramp_clk;
    logic        parabolic_en;
    logic [1:0]  int_mode;
    logic        keyed_ramp_en;
    logic        dual_ramp_en;
    logic [3:0]  deviation_shift_a;
    logic [15:0] deviation_step_a;
    logic [3:0]  deviation_shift_b;
    logic [15:0] deviation_step_b;
    logic [19:0] steps_a;
    logic [19:0] steps_b;
    logic        trig_delay;
    logic        tri_delay;
    logic        tri_delay_act;
    logic        single_tri;
    logic        trig_start_en;
    logic        fast_ramp_en;
    logic        delay_fast_lock;
    logic        ramp_delay_en;
    logic        delay_clk_sel;
    logic        delayed_start;
    logic [11:0] delay_word;
  } rwc_cfg_t;

  // Start sequencer states.
  typedef enum logic [1:0] {
    RWC_IDLE,
    RWC_DELAY,
    RWC_RUN
  } rwc_seq_t;

  // Whole state of the top module.
  typedef struct packed {
    rwc_cfg_t    cfg;
    rwc_seq_t    seq;
    logic [11:0] dly_cnt;
    logic        trig_q;
    logic        ramp_tick;
    logic        ramp_start;
    logic [11:0] cap_int;
    logic [24:0] cap_fraction;
    logic        cap_vld;
    logic        sweep_hold;
    logic        mux;
    logic        cp_up;
    logic        cp_dn;
  } rwc_main_st_t;

endpackage

// ==== src/rwc_pin_sync.sv ====
`include "rwc_defines.svh"

// Three-stage pin synchroniser; a level counts once stages two and three agree.
module rwc_pin_sync import rwc_pkg::*; (
  input  wire logic      core_clk,
  input  wire rwc_pins_t pin_raw,
  input  wire logic      srst,
  output rwc_pins_t      pin_f
);

  rwc_sync_st_t st_r;   // Registered state.
  rwc_sync_st_t st_nxt; // Next state.

  // The first stage feeds only the second; the filter looks at stages two and three.
  always_comb begin
    st_nxt      = st_r;
    st_nxt.s1   = pin_raw;
    st_nxt.s2   = st_r.s1;
    st_nxt.s3   = st_r.s2;
    st_nxt.filt = (~(st_r.s2 ^ st_r.s3) & st_r.s2) | ((st_r.s2 ^ st_r.s3) & st_r.filt);
  end

  // State register with synchronous reset.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= '{s1: `RWC_RST_PINS, s2: `RWC_RST_PINS, s3: `RWC_RST_PINS, filt: `RWC_RST_PINS};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_f = st_r.filt;

endmodule // rwc_pin_sync

// ==== src/rwc_shift_in.sv ====
`include "rwc_defines.svh"

// Serial word assembler: shifts on serial clock rise, latches on load rise.
module rwc_shift_in import rwc_pkg::*; (
  input  wire logic  core_clk,
  input  wire logic  srst,
  input  wire logic  sclk_f,
  input  wire logic  sdata_f,
  input  wire logic  latch_f,
  input  wire logic  load_sync_select,
  output logic [31:0] word,
  output logic        word_vld
);

  rwc_shift_st_t st_r;     // Registered state.
  rwc_shift_st_t st_nxt;   // Next state.
  logic          latch_rise; // Load pin rising edge.

  assign latch_rise = latch_f & ~st_r.latch_q;

  // Shift data in most significant bit first and hand the word on at the latch.
  always_comb begin
    st_nxt         = st_r;
    st_nxt.vld     = 1'b0;
    st_nxt.sclk_q  = sclk_f;
    st_nxt.latch_q = latch_f;
    st_nxt.pend    = 1'b0;
    if (sclk_f & ~st_r.sclk_q) begin
      st_nxt.sh = {st_r.sh[30:0], sdata_f};
    end
    if (st_r.pend) begin
      // Retimed latch: the word leaves one reference edge later.
      st_nxt.word = st_r.sh;
      st_nxt.vld  = 1'b1;
    end
    if (latch_rise) begin
      if (load_sync_select) begin
        st_nxt.pend = 1'b1; // RULE2
      end else begin
        st_nxt.word = st_r.sh;
        st_nxt.vld  = 1'b1;
      end
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= '{sh: `RWC_RST_WORD, sclk_q: 1'b0, latch_q: 1'b0, pend: 1'b0, word: `RWC_RST_WORD, vld: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign word     = st_r.word;
  assign word_vld = st_r.vld;

  // A retimed latch delivers exactly two edges after the load rise.
  load_sync_a: assert property (@(posedge core_clk) disable iff (srst) // RULE2
    latch_rise && load_sync_select |=> !word_vld ##1 word_vld)
    else $error("retimed load did not deliver on the second edge");

  // A plain latch delivers on the next edge.
  load_plain_a: assert property (@(posedge core_clk) disable iff (srst) // RULE2
    latch_rise && !load_sync_select |=> word_vld && word == $past(st_r.sh))
    else $error("plain load did not deliver the shifted word");

  sync_load_c: cover property (@(posedge core_clk) disable iff (srst) latch_rise && load_sync_select);

endmodule // rwc_shift_in

// ==== src/rwc_ramp_ctrl.sv ====
// Overview of operation
// RULE1: Low three bits steer word to target register.
// RULE2: Clock bit 31 retimes load to reference.
// RULE3: Mode 01110 gives integer-only, ramping disabled.
// RULE4: Host zeroes fractions, then pulses counter reset.
// RULE5: Clock bits 25:21 choose status output option.
// RULE6: Host sets output select to 1111 then.
// RULE7: Clock bits 20:19 pick ramp or fast-lock.
// RULE8: Divider mode value 11 selects ramp divider.
// RULE9: Second divider sets step timer, fast-lock time.
// RULE10: Clock bit 6 picks second divider slot.
// RULE11: Trigger edge polarity and ramp clock source.
// RULE12: Deviation bit 28 enables parabolic ramp.
// RULE13: Trigger rise captures values; sweep continues/stops.
// RULE14: Bits 25, 24 enable keyed and second ramp.
// RULE15: Bit 23 selects deviation word; shift, step.
// RULE16: Step bit 23 selects word; 20-bit count.
// RULE17: Trigger start delay needs delayed start too.
// RULE18: Triangle clipping delay only with ramp delay.
// RULE19: Single full triangle; host sets ramp mode.
// RULE20: Trigger high starts ramp when enabled.
// RULE21: Bit 19 enables two-slope fast ramp.
// RULE22: Bits 18, 17: delay fast-lock, ramp delay.
// RULE23: Delay clock: reference or first divider ticks.
// RULE24: Delayed start enable and 12-bit duration.
// RULE25: Host follows fixed power-up programming order.
`include "rwc_defines.svh"

module rwc_ramp_ctrl import rwc_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire rwc_ser_t    ser,
  input  wire logic        trigger_pin,
  input  wire logic        first_ramp_divider_tick,
  input  wire logic        ramp_done,
  input  wire logic [11:0] int_value,
  input  wire logic [24:0] fractional_divide_value,
  output rwc_cfg_t         cfg,
  output logic             ramp_tick,
  output logic             ramp_start,
  output logic [11:0]      cap_int_value,
  output logic [24:0]      cap_fractional_value,
  output logic             sweep_hold,
  output logic             multiplexed_output_pin,
  output logic             cp_force_up,
  output logic             cp_force_dn
);

  ////////////////////////////////////////////////////////////////////////////////
  // Pin front end
  ////////////////////////////////////////////////////////////////////////////////

  rwc_main_st_t st_r;      // Registered state.
  rwc_main_st_t st_nxt;    // Next state.
  rwc_pins_t    pin_f;     // Filtered pin levels.
  logic [31:0]  word;      // Latched serial word.
  logic         word_vld;  // One-cycle strobe with a new word.
  logic         trig_f;    // Filtered trigger level.
  logic         trig_rise; // Trigger rising edge.
  logic         trig_fall; // Trigger falling edge.
  logic         idle_go;   // Start request seen while idle.
  logic         delay_tick; // One tick of the chosen delay clock.

  // Serial and trigger pins cross into the reference clock domain here.
  rwc_pin_sync u_sync (
    .core_clk (core_clk),
    .pin_raw  ({trigger_pin, ser.sclk, ser.sdata, ser.load_latch_pin}),
    .srst     (srst),
    .pin_f    (pin_f)
  );

  // Words are assembled from the filtered levels.
  rwc_shift_in u_shift (
    .core_clk         (core_clk),
    .srst             (srst),
    .sclk_f           (pin_f[2]),
    .sdata_f          (pin_f[1]),
    .latch_f          (pin_f[0]),
    .load_sync_select (st_r.cfg.load_sync_select),
    .word             (word),
    .word_vld         (word_vld)
  );

  assign trig_f     = pin_f[3];
  assign trig_rise  = trig_f & ~st_r.trig_q;
  assign trig_fall  = ~trig_f & st_r.trig_q;
  assign idle_go    = (st_r.seq == RWC_IDLE) & st_r.cfg.trig_start_en & trig_f & st_r.cfg.modulator_on;
  assign delay_tick = st_r.cfg.delay_clk_sel ? first_ramp_divider_tick : 1'b1; // RULE23

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  ////////////////////////////////////////////////////////////////////////////////

  // Decodes words, runs the trigger and start logic and builds the outputs.
  always_comb begin
    st_nxt            = st_r;
    st_nxt.trig_q     = trig_f;
    st_nxt.ramp_start = 1'b0;

    // Register writes; codes below four belong to other registers and are ignored here.
    if (word_vld) begin
      unique case (word[`RWC_F_ADDR]) // RULE1
        `RWC_ADDR_CLOCK: begin
          st_nxt.cfg.load_sync_select = word[`RWC_B_LOAD_SYNC]; // RULE2
          st_nxt.cfg.int_only     = (word[`RWC_F_MOD_MODE] == `RWC_MOD_INT_ONLY); // RULE3
          st_nxt.cfg.status_sel   = word[`RWC_F_STATUS]; // RULE5
          st_nxt.cfg.ramp_div_en  = (word[`RWC_F_DIV_MODE] == `RWC_DIV_RAMP); // RULE7 RULE8
          st_nxt.cfg.fast_lock_en = (word[`RWC_F_DIV_MODE] == `RWC_DIV_FASTLOCK); // RULE7
          if (word[`RWC_B_DIV_SELECT]) begin
            st_nxt.cfg.second_ramp_divider_b = word[`RWC_F_SECOND_DIV]; // RULE9 RULE10
          end else begin
            st_nxt.cfg.second_ramp_divider_a = word[`RWC_F_SECOND_DIV]; // RULE9 RULE10
          end
        end
        `RWC_ADDR_DEVIATION: begin
          st_nxt.cfg.trig_falling  = word[`RWC_B_TRIG_FALLING]; // RULE11
          st_nxt.cfg.trig_ramp_clk = word[`RWC_B_TRIG_RAMP_CLK]; // RULE11
          st_nxt.cfg.parabolic_en  = word[`RWC_B_PARABOLIC]; // RULE12
          st_nxt.cfg.int_mode      = word[`RWC_F_INT_MODE]; // RULE13
          st_nxt.cfg.keyed_ramp_en = word[`RWC_B_KEYED_RAMP]; // RULE14
          st_nxt.cfg.dual_ramp_en  = word[`RWC_B_DUAL_RAMP]; // RULE14
          // A new interrupt setting releases a held sweep and the pending readback.
          st_nxt.sweep_hold = 1'b0;
          st_nxt.cap_vld    = 1'b0;
          if (word[`RWC_B_WORD_SELECT]) begin
            st_nxt.cfg.deviation_shift_b = word[`RWC_F_DEV_SHIFT]; // RULE15
            st_nxt.cfg.deviation_step_b  = word[`RWC_F_DEV_STEP]; // RULE15
          end else begin
            st_nxt.cfg.deviation_shift_a = word[`RWC_F_DEV_SHIFT]; // RULE15
            st_nxt.cfg.deviation_step_a  = word[`RWC_F_DEV_STEP]; // RULE15
          end
        end
        `RWC_ADDR_STEP: begin
          if (word[`RWC_B_WORD_SELECT]) begin
            st_nxt.cfg.steps_b = word[`RWC_F_STEP_COUNT]; // RULE16
          end else begin
            st_nxt.cfg.steps_a = word[`RWC_F_STEP_COUNT]; // RULE16
          end
        end
        `RWC_ADDR_DELAY: begin
          st_nxt.cfg.trig_delay      = word[`RWC_B_TRIG_DELAY]; // RULE17
          st_nxt.cfg.tri_delay       = word[`RWC_B_TRI_DELAY]; // RULE18
          st_nxt.cfg.single_tri      = word[`RWC_B_SINGLE_TRI]; // RULE19
          st_nxt.cfg.trig_start_en   = word[`RWC_B_TRIG_START]; // RULE20
          st_nxt.cfg.fast_ramp_en    = word[`RWC_B_FAST_RAMP]; // RULE21
          st_nxt.cfg.delay_fast_lock = word[`RWC_B_DLY_FASTLOCK]; // RULE22
          st_nxt.cfg.ramp_delay_en   = word[`RWC_B_RAMP_DELAY]; // RULE22
          st_nxt.cfg.delay_clk_sel   = word[`RWC_B_DLY_CLK_SEL]; // RULE23
          st_nxt.cfg.delayed_start   = word[`RWC_B_DLY_START]; // RULE24
          st_nxt.cfg.delay_word      = word[`RWC_F_DLY_WORD]; // RULE24
        end
        default: begin
          st_nxt.cfg = st_r.cfg;
        end
      endcase
    end

    // Derived enables; clipping only counts while the ramp delay is on.
    st_nxt.cfg.modulator_on  = ~st_nxt.cfg.int_only; // RULE3
    st_nxt.cfg.tri_delay_act = st_nxt.cfg.tri_delay & st_nxt.cfg.ramp_delay_en; // RULE18

    // Ramp clock: divider ticks or the active trigger edge; none in integer-only mode.
    st_nxt.ramp_tick = st_r.cfg.modulator_on & ~st_r.sweep_hold & // RULE3
                       (st_r.cfg.trig_ramp_clk ? (st_r.cfg.trig_falling ? trig_fall : trig_rise) // RULE11
                                               : first_ramp_divider_tick);

    // Trigger rise captures the current values; set wins over a same-cycle clear.
    if ((st_r.cfg.int_mode != `RWC_INT_OFF) && trig_rise) begin
      st_nxt.cap_int      = int_value; // RULE13
      st_nxt.cap_fraction = fractional_divide_value; // RULE13
      st_nxt.cap_vld      = 1'b1;
      if (st_r.cfg.int_mode == `RWC_INT_STOP) begin
        st_nxt.sweep_hold = 1'b1; // RULE13
      end
    end

    // Start sequencer: a high trigger starts a ramp, optionally after a delay.
    unique case (st_r.seq)
      RWC_IDLE: begin
        if (idle_go) begin
          if (st_r.cfg.trig_delay & st_r.cfg.delayed_start) begin
            st_nxt.dly_cnt = st_r.cfg.delay_word; // RULE17 RULE24
            st_nxt.seq     = RWC_DELAY;
          end else begin
            st_nxt.ramp_start = 1'b1; // RULE20
            st_nxt.seq        = RWC_RUN;
          end
        end
      end
      RWC_DELAY: begin
        if (delay_tick) begin
          if (st_r.dly_cnt == 12'h000) begin
            st_nxt.ramp_start = 1'b1; // RULE17
            st_nxt.seq        = RWC_RUN;
          end else begin
            st_nxt.dly_cnt = st_r.dly_cnt - 12'h001; // RULE24
          end
        end
      end
      RWC_RUN: begin
        // The ramp engine reports the end; a still-high trigger then restarts.
        if (ramp_done) begin
          st_nxt.seq = RWC_IDLE;
        end
      end
    endcase
    // Integer-only mode stops any pending or running start.
    if (st_r.cfg.int_only) begin
      st_nxt.seq        = RWC_IDLE;
      st_nxt.ramp_start = 1'b0; // RULE3
    end

    // Status routing to the multiplexed pin and the forced charge pump.
    unique case (st_r.cfg.status_sel) // RULE5
      `RWC_STAT_READBACK:  st_nxt.mux = st_r.cap_vld;
      `RWC_STAT_RAMP_DONE: st_nxt.mux = ramp_done;
      default:             st_nxt.mux = 1'b0;
    endcase
    st_nxt.cp_up = (st_r.cfg.status_sel == `RWC_STAT_CP_UP); // RULE5
    st_nxt.cp_dn = (st_r.cfg.status_sel == `RWC_STAT_CP_DOWN); // RULE5
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  ////////////////////////////////////////////////////////////////////////////////

  // Synchronous reset puts every field, and so every output, at zero.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg                    = st_r.cfg;
  assign ramp_tick              = st_r.ramp_tick;
  assign ramp_start             = st_r.ramp_start;
  assign cap_int_value          = st_r.cap_int;
  assign cap_fractional_value   = st_r.cap_fraction;
  assign sweep_hold             = st_r.sweep_hold;
  assign multiplexed_output_pin = st_r.mux;
  assign cp_force_up            = st_r.cp_up;
  assign cp_force_dn            = st_r.cp_dn;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  ////////////////////////////////////////////////////////////////////////////////

  default clocking rwc_cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // Step words with bit 23 set land in slot b and leave slot a alone.
  step_slot_a: assert property ( // RULE16
    word_vld && word[2:0] == 3'h6 && word[23] |=> cfg.steps_b == $past(word[22:3]) && $stable(cfg.steps_a))
    else $error("step word landed in the wrong slot");

  // A clock word with bit 6 clear loads second divider slot a.
  div_slot_a: assert property ( // RULE10
    word_vld && word[2:0] == 3'h4 && !word[6] |=> cfg.second_ramp_divider_a == $past(word[18:7]))
    else $error("second divider slot a not loaded");

  // Integer-only code turns the modulator off and blocks starts.
  int_only_a: assert property ( // RULE3
    word_vld && word[2:0] == 3'h4 && word[30:26] == 5'h0E |=> cfg.int_only && !cfg.modulator_on ##1 !ramp_start)
    else $error("integer-only mode not entered");

  // Divider mode 11 enables the ramp divider only.
  div_mode_a: assert property ( // RULE8
    word_vld && word[2:0] == 3'h4 && word[20:19] == 2'h3 |=> cfg.ramp_div_en && !cfg.fast_lock_en)
    else $error("ramp divider mode not selected");

  // Forced charge pump follows the status field one edge later.
  cp_force_a: assert property ( // RULE5
    cfg.status_sel == 5'h10 |=> cp_force_up && !cp_force_dn)
    else $error("charge pump up not forced");

  // A falling-edge trigger clock ticks one edge after a fall.
  trig_edge_a: assert property ( // RULE11
    cfg.trig_ramp_clk && cfg.trig_falling && cfg.modulator_on && !sweep_hold && trig_fall |=> ramp_tick)
    else $error("ramp tick missed on falling trigger");

  // Capture takes the live values on a trigger rise.
  capture_a: assert property ( // RULE13
    cfg.int_mode != 2'h0 && trig_rise |=> cap_int_value == $past(int_value) && cap_fractional_value == $past(fractional_divide_value))
    else $error("trigger capture missed");

  // Without the double enable the start comes on the next edge.
  start_now_a: assert property ( // RULE20
    idle_go && !(cfg.trig_delay && cfg.delayed_start) && !cfg.int_only |=> ramp_start)
    else $error("undelayed trigger start missing");

  // With both delay bits and a zero word, no start on the first edge, one on the second.
  start_delay_a: assert property ( // RULE17
    idle_go && cfg.trig_delay && cfg.delayed_start && cfg.delay_word == 12'h000 && !cfg.delay_clk_sel
    |=> !ramp_start ##1 ramp_start)
    else $error("delayed trigger start mistimed");

  // Clipping follows the triangle delay bit only when the same word also sets the ramp delay.
  tri_clip_a: assert property ( // RULE18
    word_vld && word[2:0] == 3'h7 |=> cfg.tri_delay_act == ($past(word[22]) && $past(word[17])))
    else $error("triangle clipping not tied to ramp delay");

  int_only_c: cover property (cfg.int_only);
  delayed_start_c: cover property (st_r.seq == RWC_DELAY ##1 ramp_start);
  hold_c: cover property (sweep_hold);

endmodule // rwc_ramp_ctrl

// ==== verif/rwc_host_model.sv ====
// Host side of the three-wire port: sends words MSB first and pulses the load pin.
module rwc_host_model import rwc_pkg::*; (
  input  wire logic core_clk,
  output rwc_ser_t  ser
);
  timeunit 1ns;
  timeprecision 1ps;

  // Each level is held five reference cycles so the three-stage filter takes it.
  task automatic hold();
    repeat (5) @(posedge core_clk);
  endtask

  // The clock stands low outside frames and data flips after a frame, so no stale bit looks valid.
  task automatic send(input logic [31:0] w);
    @(posedge core_clk);
    for (int i = 31; i >= 0; i--) begin
      ser.sdata <= w[i];
      hold();
      ser.sclk <= 1'b1;
      hold();
      ser.sclk <= 1'b0;
    end
    hold();
    ser.load_latch_pin <= 1'b1;
    hold();
    ser.load_latch_pin <= 1'b0;
    ser.sdata          <= ~ser.sdata;
    hold();
  endtask

  // Power-up order: delay, both steps, both deviations, both clocks, then the lower registers.
  task automatic power_up();
    logic [31:0] ws [11] = '{32'h0000_0007, 32'h0000_0006, 32'h0080_0006, 32'h0000_0005, 32'h0080_0005,
                             32'h0000_0004, 32'h0000_0044, 32'h0002_0C03, 32'h0000_0002, 32'h0000_0001,
                             32'h0000_0000};
    foreach (ws[i]) send(ws[i]);
  endtask

  // Host duties after a clock word: output select 1111, zeroed fractions and the counter-reset pair.
  task automatic after_clock(input logic [31:0] w);
    if (w[30:26] == 5'h0E || w[25:21] inside {5'h02, 5'h03}) send(32'h7800_0000);
    if (w[30:26] == 5'h0E) begin
      send(32'h0000_0001);
      send(32'h0002_000B);
      send(32'h0002_0003);
    end
  endtask

  initial ser = '0;
endmodule // rwc_host_model

// ==== verif/tb_rwc_ramp_ctrl.sv ====
// Table of register writes, then trigger start, capture and status pin checks.
module tb_rwc_ramp_ctrl import rwc_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct { logic [31:0] w; int k; logic [31:0] e; } rwc_row_t;
  logic        core_clk    = 1'b0;
  logic        srst        = 1'b1;
  logic        trigger_pin = 1'b0;
  logic        ramp_done   = 1'b0;
  logic        div_tick    = 1'b0;
  rwc_cfg_t    cfg_idle;
  rwc_ser_t    ser;
  rwc_cfg_t    cfg;
  logic        ramp_tick, ramp_start, sweep_hold, mux_pin, cp_up, cp_dn;
  logic [11:0] cap_int;
  logic [24:0] cap_fractional_divide_value;
  int          errors      = 0;
  int          checks_done = 0;
  int          cyc         = 0;
  int          n;
  // Rows: word, field group, expected group value.
  rwc_row_t rows [10] = '{
    '{32'h001D_5E04, 0, 32'h0000_2ABC},
    '{32'h0008_91C4, 1, 32'h0000_1123},
    '{32'h5ECC_000D, 2, 32'h05E9_8001},
    '{32'h007F_FFFE, 3, 32'h000F_FFFF},
    '{32'h0080_002E, 4, 32'h0000_0005},
    '{32'hFFFF_FFFB, 4, 32'h0000_0005},
    '{32'h0090_801F, 5, 32'h0012_1003},
    '{32'h3860_0004, 6, 32'h0000_0043},
    '{32'h0200_0004, 6, 32'h0000_0030},
    '{32'h8060_0004, 6, 32'h0000_00A3}};

  always #20 core_clk = ~core_clk;

  rwc_host_model u_rwc_host_model (.core_clk(core_clk), .ser(ser));

  rwc_ramp_ctrl u_rwc_ramp_ctrl (
    .core_clk(core_clk), .srst(srst), .ser(ser), .trigger_pin(trigger_pin),
    .first_ramp_divider_tick(div_tick), .ramp_done(ramp_done), .int_value(12'h5A5),
    .fractional_divide_value(25'h0ABCDEF), .cfg(cfg), .ramp_tick(ramp_tick),
    .ramp_start(ramp_start), .cap_int_value(cap_int), .cap_fractional_value(cap_fractional_divide_value),
    .sweep_hold(sweep_hold), .multiplexed_output_pin(mux_pin), .cp_force_up(cp_up),
    .cp_force_dn(cp_dn));

  // Counts and reports one comparison.
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Picks one group of configuration fields.
  function automatic logic [31:0] fld(input int k);
    case (k)
      0: fld = 32'({cfg.ramp_div_en, cfg.fast_lock_en, cfg.second_ramp_divider_a});
      1: fld = 32'({cfg.ramp_div_en, cfg.fast_lock_en, cfg.second_ramp_divider_b});
      2: fld = 32'({cfg.trig_falling, cfg.trig_ramp_clk, cfg.parabolic_en, cfg.int_mode, cfg.keyed_ramp_en,
                    cfg.dual_ramp_en, cfg.deviation_shift_b, cfg.deviation_step_b});
      3: fld = 32'(cfg.steps_a);
      4: fld = 32'(cfg.steps_b);
      5: fld = 32'({cfg.trig_delay, cfg.tri_delay, cfg.single_tri, cfg.trig_start_en, cfg.fast_ramp_en,
                    cfg.delay_fast_lock, cfg.ramp_delay_en, cfg.delay_clk_sel, cfg.delayed_start, cfg.delay_word});
      default: fld = 32'({cfg.load_sync_select, cfg.int_only, cfg.modulator_on, cfg.status_sel});
    endcase
  endfunction

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("Checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Cuts a hang short well past the expected run of about nine thousand cycles.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end

  initial begin
    // Idle configuration: all fields zero, modulator on because mode 00000 is normal operation.
    cfg_idle              = '0;
    cfg_idle.modulator_on = 1'b1;
    repeat (8) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("cfg reset", 32'h1, {31'h0, cfg === cfg_idle});
    chk("cp up", 32'h0, {31'h0, cp_up});
    u_rwc_host_model.power_up();
    chk("power up", 32'h1, {31'h0, cfg === cfg_idle});
    $display("Power-up test done");
    foreach (rows[i]) begin
      u_rwc_host_model.send(rows[i].w);
      if (rows[i].w[2:0] == 3'h4) u_rwc_host_model.after_clock(rows[i].w);
      chk($sformatf("row %0d", i), rows[i].e, fld(rows[i].k));
      if (rows[i].w == 32'h0200_0004) chk("cp up", 32'h1, {31'h0, cp_up});
    end
    $display("Register table done");
    // With the divider as ramp clock, one divider tick gives one ramp tick an edge later.
    @(posedge core_clk) div_tick <= 1'b1;
    @(posedge core_clk) div_tick <= 1'b0;
    #1;
    chk("ramp tick", 32'h1, {31'h0, ramp_tick});
    $display("Divider tick test done");
    // Delayed start with word 3 must hold the start back past the plain one-cycle path.
    n = 0;
    @(posedge core_clk) trigger_pin <= 1'b1;
    while (ramp_start !== 1'b1 && n < 40) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk("start delay", 32'h1, {31'h0, n >= 7 && n <= 12});
    chk("capture int", 32'h5A5, 32'(cap_int));
    chk("capture fractional_divide_value", 32'h0ABCDEF, 32'(cap_fractional_divide_value));
    chk("sweep hold", 32'h1, {31'h0, sweep_hold});
    $display("Trigger test done");
    // Ramp-done status shows the end pulse one cycle late on the status pin.
    @(posedge core_clk) ramp_done <= 1'b1;
    @(posedge core_clk) ramp_done <= 1'b0;
    #1;
    chk("status pin", 32'h1, {31'h0, mux_pin});
    @(posedge core_clk) trigger_pin <= 1'b0;
    #1;
    chk("status pin", 32'h0, {31'h0, mux_pin});
    $display("Status pin test done");
    // A mid-run reset returns every field and the held sweep to idle.
    @(posedge core_clk) srst <= 1'b1;
    repeat (4) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("cfg reset", 32'h1, {31'h0, cfg === cfg_idle});
    chk("hold reset", 32'h0, {31'h0, sweep_hold});
    $display("Reset test done");
    test_done();
  end
endmodule // tb_rwc_ramp_ctrl
